// ==== verilog/warn_agg.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Switchable warnings: latch or one-second hold
// - Battery and lifetime warnings always latch
// - Two outputs, each routes its selected warning
// - Select zero outputs OR of all warnings
// - Mask bit set suppresses that warning's detection
// - Extended warnings have own disable setting
// - Tool command warning: enable, link, operation
// - Supply phase failure beyond time raises power-off
// - Power-off detect active only for 10..1999
// - No battery warning under single-turn absolute
// - Alarm clear clears; standing cause re-raises
// - Deterioration warning off when enhancement bit clear
module warn_agg
  import warn_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int HOLD_LEN = HOLD_TICKS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Warning causes from the drive
  input wire logic [WARN_COUNT-1:0] warn_cause_i,
  input wire logic supply_phase_fail_i,
  input wire logic link_up_i,
  input wire logic tool_op_i,
  // Warning outputs
  output logic warn_out_one_o,
  output logic warn_out_two_o,
  output logic [WARN_COUNT-1:0] warn_active_o,
  output logic irq_o
);

  localparam int TW = $clog2(TICK_LEN);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_LEN - 1);

  cfg_t cfg_reg, cfg_next;
  logic clr_reg, clr_next;
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [WARN_COUNT-1:0] irq_stat_reg, irq_stat_next;
  logic [WARN_COUNT-1:0] irq_mask_reg, irq_mask_next;
  logic [WARN_COUNT-1:0] act_prev_reg;
  logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  logic [10:0] pf_cnt_reg, pf_cnt_next;
  logic out_one_reg, out_one_next, out_two_reg, out_two_next;

  logic [WARN_COUNT-1:0] cause_sync, cause_raw, cause_eff, active;
  logic [2:0] misc_sync;
  logic pf_sync, link_sync, tool_sync;
  logic [31:0] mask_all;
  logic do_write, stat_rd;
  logic pwr_window;

  // Every warning cause pin crosses two flip-flops first
  warn_sync #(.W(WARN_COUNT)) u_sync_cause (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .d_i(warn_cause_i),
    .q_o(cause_sync)
  );

  warn_sync #(.W(3)) u_sync_misc (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .d_i({supply_phase_fail_i, link_up_i, tool_op_i}),
    .q_o(misc_sync)
  );

  assign pf_sync = misc_sync[2];
  assign link_sync = misc_sync[1];
  assign tool_sync = misc_sync[0];

  // Detection conditions
  assign pwr_window = (cfg_reg.pwr_time >= PWR_TIME_MIN) &&
                      (cfg_reg.pwr_time <= PWR_TIME_MAX);
  assign mask_all = {cfg_reg.mask_secondary, cfg_reg.mask_primary};

  always_comb begin
    cause_raw = cause_sync;
    if (cfg_reg.abs_single_turn) begin
      cause_raw[W_BATTERY] = 1'b0;
    end
    if (!cfg_reg.func_enh_three[FUNC_THREE_DET_BIT]) begin
      cause_raw[W_DETERIOR] = 1'b0;
    end
    // Failure must still stand: the count lags the pin by one cycle
    cause_raw[W_POWER_OFF] = pwr_window && pf_sync &&
      ({5'h00, pf_cnt_reg} > cfg_reg.pwr_time);
    cause_raw[W_TOOL_CMD] = cfg_reg.enh_six[ENH_SIX_TOOL_BIT] &&
      link_sync && tool_sync;
  end

  genvar gi;
  generate
    for (gi = 0; gi < WARN_COUNT; gi++) begin : g_warn
      logic ext_off;
      if (gi >= EXT_BASE) begin : g_ext
        assign ext_off = cfg_reg.ext_disable[gi - EXT_BASE];
      end else begin : g_gen
        assign ext_off = 1'b0;
      end
      assign cause_eff[gi] = cause_raw[gi] &&
        !mask_all[MASK_POS[gi]] && !ext_off;
      warn_cell #(
        .HOLD_TICKS(HOLD_LEN),
        .FIXED_LATCH(LATCH_FIXED[gi])
      ) u_cell (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .cause_i(cause_eff[gi]),
        .latch_i(cfg_reg.latch_mode),
        .clear_i(clr_reg),
        .tick_i(tick),
        .active_o(active[gi])
      );
    end
  endgenerate

  // Output routing; only listed codes are meaningful
  function automatic logic route(input logic [4:0] sel,
                                 input logic [WARN_COUNT-1:0] act);
    logic hit;
    hit = 1'b0;
    if (sel == 5'h00) begin
      hit = |act;
    end else begin
      for (int i = 0; i < WARN_COUNT; i++) begin
        if (SEL_CODE[i] == sel) begin
          hit = hit | act[i];
        end
      end
    end
    return hit;
  endfunction : route

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // Timers: 1 ms tick and power-failure duration in ms
  assign tick = (tick_cnt_reg == TICK_LAST);

  always_comb begin
    tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
    pf_cnt_next = pf_cnt_reg;
    if (!pf_sync) begin
      pf_cnt_next = '0;
    end else if (tick && pf_cnt_reg != 11'h7FF) begin
      pf_cnt_next = pf_cnt_reg + 1'b1;
    end
    out_one_next = route(cfg_reg.sel_one, active);
    out_two_next = route(cfg_reg.sel_two, active);
  end

  // Register bus
  assign awready = !aw_full_reg && !bvalid_reg;
  assign wready = !w_full_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign stat_rd = arvalid && arready && (araddr == OFS_IRQ_STATUS);

  always_comb begin
    logic [31:0] wm;
    logic [31:0] cur;
    wm = '0;
    cur = '0;
    cfg_next = cfg_reg;
    clr_next = 1'b0;
    irq_mask_next = irq_mask_reg;
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg && !bready;
    bresp_next = bresp_reg;
    if (awvalid && awready) begin
      aw_full_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_full_next = 1'b1;
      w_data_next = wdata;
      w_strb_next = wstrb;
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (aw_addr_reg)
        OFS_CTRL: begin
          cur = {29'h0, cfg_reg.abs_single_turn, 1'b0, cfg_reg.latch_mode};
          wm = merge(cur, w_data_reg, w_strb_reg);
          cfg_next.latch_mode = wm[CTRL_LATCH_BIT];
          cfg_next.abs_single_turn = wm[CTRL_ABS_BIT];
          clr_next = wm[CTRL_CLEAR_BIT];
        end
        OFS_OUT_SEL: begin
          cur = {19'h0, cfg_reg.sel_two, 3'h0, cfg_reg.sel_one};
          wm = merge(cur, w_data_reg, w_strb_reg);
          cfg_next.sel_one = wm[SEL_ONE_LSB +: 5];
          cfg_next.sel_two = wm[SEL_TWO_LSB +: 5];
        end
        OFS_MASK_PRIMARY: begin
          wm = merge({16'h0, cfg_reg.mask_primary}, w_data_reg, w_strb_reg);
          cfg_next.mask_primary = wm[15:0];
        end
        OFS_MASK_SECONDARY: begin
          wm = merge({16'h0, cfg_reg.mask_secondary}, w_data_reg,
                     w_strb_reg);
          cfg_next.mask_secondary = wm[15:0];
        end
        OFS_LINK_ENH_SIX: begin
          wm = merge({16'h0, cfg_reg.enh_six}, w_data_reg, w_strb_reg);
          cfg_next.enh_six = wm[15:0];
        end
        OFS_FUNC_ENH_THREE: begin
          wm = merge({16'h0, cfg_reg.func_enh_three}, w_data_reg,
                     w_strb_reg);
          cfg_next.func_enh_three = wm[15:0];
        end
        OFS_PWR_TIME: begin
          wm = merge({16'h0, cfg_reg.pwr_time}, w_data_reg, w_strb_reg);
          cfg_next.pwr_time = wm[15:0];
        end
        OFS_EXT_DISABLE: begin
          wm = merge({27'h0, cfg_reg.ext_disable}, w_data_reg, w_strb_reg);
          cfg_next.ext_disable = wm[EXT_COUNT-1:0];
        end
        OFS_IRQ_MASK: begin
          wm = merge({16'h0, irq_mask_reg}, w_data_reg, w_strb_reg);
          irq_mask_next = wm[15:0];
        end
        OFS_WARN_ACTIVE, OFS_IRQ_STATUS: begin
          bresp_next = RESP_OKAY;
        end
        default: begin
          bresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    rvalid_next = rvalid_reg && !rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (araddr)
        OFS_CTRL: rdata_next = {29'h0, cfg_reg.abs_single_turn, 1'b0,
                                cfg_reg.latch_mode};
        OFS_OUT_SEL: rdata_next = {19'h0, cfg_reg.sel_two, 3'h0,
                                   cfg_reg.sel_one};
        OFS_MASK_PRIMARY: rdata_next = {16'h0, cfg_reg.mask_primary};
        OFS_MASK_SECONDARY: rdata_next = {16'h0, cfg_reg.mask_secondary};
        OFS_LINK_ENH_SIX: rdata_next = {16'h0, cfg_reg.enh_six};
        OFS_FUNC_ENH_THREE: rdata_next = {16'h0, cfg_reg.func_enh_three};
        OFS_PWR_TIME: rdata_next = {16'h0, cfg_reg.pwr_time};
        OFS_EXT_DISABLE: rdata_next = {27'h0, cfg_reg.ext_disable};
        OFS_WARN_ACTIVE: rdata_next = {16'h0, active};
        OFS_IRQ_STATUS: rdata_next = {16'h0, irq_stat_reg};
        OFS_IRQ_MASK: rdata_next = {16'h0, irq_mask_reg};
        default: begin
          rdata_next = '0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    // A new rising warning in the read cycle survives the read clear
    irq_stat_next = (stat_rd ? '0 : irq_stat_reg) |
                    (active & ~act_prev_reg);
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_reg <= CFG_RESET;
      clr_reg <= 1'b0;
      irq_mask_reg <= '0;
      irq_stat_reg <= '0;
      act_prev_reg <= '0;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      tick_cnt_reg <= '0;
      pf_cnt_reg <= '0;
      out_one_reg <= 1'b0;
      out_two_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      clr_reg <= clr_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
      act_prev_reg <= active;
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      tick_cnt_reg <= tick_cnt_next;
      pf_cnt_reg <= pf_cnt_next;
      out_one_reg <= out_one_next;
      out_two_reg <= out_two_next;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign warn_out_one_o = out_one_reg;
  assign warn_out_two_o = out_two_reg;
  assign warn_active_o = active;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_clear_drops: assert property (clr_reg |=> active == '0)
    else $error("alarm clear left a warning active");
  a_clear_reraise: assert property (
    clr_reg ##1 cause_eff[0] |=> active[0])
    else $error("standing cause not raised again after clear");
  a_or_route: assert property (
    cfg_reg.sel_one == 5'h00 |=> warn_out_one_o == $past(|active))
    else $error("select zero did not give OR of warnings");
  a_code_route: assert property (
    cfg_reg.sel_two == 5'h1E |=> warn_out_two_o == $past(active[15]))
    else $error("output two did not follow selected warning");
  a_mask_block: assert property (
    cfg_reg.mask_secondary[8] |-> !cause_eff[W_TOOL_CMD])
    else $error("masked warning still detected");
  a_fixed_latch: assert property (
    active[W_BATTERY] && !clr_reg |=> active[W_BATTERY])
    else $error("battery warning dropped without clear");
  a_latch_hold: assert property (
    cfg_reg.latch_mode && active[0] && !clr_reg |=> active[0])
    else $error("latched warning dropped without clear");
  a_hold_raise: assert property (
    !clr_reg && cause_eff[0] ##1 !clr_reg |-> active[0] ##1 active[0])
    else $error("warning not held after cause");
  a_tool_cause: assert property (
    cause_eff[W_TOOL_CMD] |-> cfg_reg.enh_six[0] && link_sync)
    else $error("tool command warning without enable and link");
  a_power_window: assert property (
    cause_eff[W_POWER_OFF] |-> pwr_window && pf_sync)
    else $error("power-off warning outside enabling range");
  a_power_detect: assert property (
    pwr_window && pf_sync && !mask_all[MASK_POS[W_POWER_OFF]] &&
    !cfg_reg.ext_disable[3] && $stable(cfg_reg.pwr_time) &&
    ({5'h00, pf_cnt_reg} > cfg_reg.pwr_time) |-> cause_eff[W_POWER_OFF])
    else $error("long supply failure did not raise power-off");
  a_abs_battery: assert property (
    cfg_reg.abs_single_turn |-> !cause_eff[W_BATTERY])
    else $error("battery detected under single-turn absolute");
  a_deterior_off: assert property (
    !cfg_reg.func_enh_three[1] |-> !cause_eff[W_DETERIOR])
    else $error("deterioration detected while disabled");
  a_ext_disable: assert property (
    cfg_reg.ext_disable[0] |-> !cause_eff[EXT_BASE])
    else $error("disabled extended warning detected");

  c_clear_seen: cover property (clr_reg ##1 active == '0);
  c_nonlatch_drop: cover property (
    !cfg_reg.latch_mode && $fell(active[0]) && !$past(clr_reg));
  c_tool_warn: cover property ($rose(active[W_TOOL_CMD]));
  c_irq: cover property ($rose(irq_o));

endmodule : warn_agg

`default_nettype wire

// ==== verilog/warn_pkg.sv ====
package warn_pkg;

  localparam int WARN_COUNT = 16;
  localparam int EXT_COUNT = 5;
  localparam int EXT_BASE = 11;
  localparam int ADDR_W = 8;

  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int HOLD_TIME_MS = 1000;
  localparam int HOLD_TICKS = HOLD_TIME_MS * 1000 / TICK_TIME_US;
  localparam logic [15:0] PWR_TIME_MIN = 16'h000A;
  localparam logic [15:0] PWR_TIME_MAX = 16'h07CF;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK_PRIMARY = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK_SECONDARY = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LINK_ENH_SIX = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FUNC_ENH_THREE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PWR_TIME = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EXT_DISABLE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_WARN_ACTIVE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h28;

  // Field positions
  localparam int CTRL_LATCH_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int CTRL_ABS_BIT = 2;
  localparam int SEL_ONE_LSB = 0;
  localparam int SEL_TWO_LSB = 8;
  localparam int ENH_SIX_TOOL_BIT = 0;
  localparam int FUNC_THREE_DET_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per warning: output select code, bit in {secondary, primary} mask
  localparam logic [4:0] SEL_CODE [0:WARN_COUNT-1] = '{
    5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
    5'h09, 5'h0A, 5'h16, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h1E};
  localparam logic [4:0] MASK_POS [0:WARN_COUNT-1] = '{
    5'h07, 5'h05, 5'h00, 5'h06, 5'h04, 5'h03, 5'h0D, 5'h02,
    5'h08, 5'h0E, 5'h17, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h18};
  localparam logic [WARN_COUNT-1:0] LATCH_FIXED = 16'h3084;

  localparam int W_BATTERY = 2;
  localparam int W_DETERIOR = 10;
  localparam int W_POWER_OFF = 14;
  localparam int W_TOOL_CMD = 15;

  typedef struct packed {
    logic latch_mode;
    logic abs_single_turn;
    logic [4:0] sel_one;
    logic [4:0] sel_two;
    logic [15:0] mask_primary;
    logic [15:0] mask_secondary;
    logic [15:0] enh_six;
    logic [15:0] func_enh_three;
    logic [15:0] pwr_time;
    logic [EXT_COUNT-1:0] ext_disable;
  } cfg_t;

  localparam cfg_t CFG_RESET = '0;

endpackage : warn_pkg

// ==== verilog/warn_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module warn_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;

endmodule : warn_sync

`default_nettype wire

// ==== verilog/warn_cell.sv ====
`timescale 1ns/1ps
`default_nettype none

module warn_cell #(
  parameter int HOLD_TICKS = 1000,
  parameter bit FIXED_LATCH = 1'b0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Control
  input wire logic cause_i,
  input wire logic latch_i,
  input wire logic clear_i,
  input wire logic tick_i,
  // State
  output logic active_o
);

  localparam int CW = $clog2(HOLD_TICKS + 1);
  localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_TICKS);

  logic active_reg, active_next;
  logic [CW-1:0] hold_reg, hold_next;
  logic latched;

  assign latched = latch_i | FIXED_LATCH;

  always_comb begin
    active_next = active_reg;
    hold_next = hold_reg;
    if (clear_i) begin
      // Clear wins for one cycle; a standing cause re-raises next cycle
      active_next = 1'b0;
      hold_next = '0;
    end else if (cause_i) begin
      active_next = 1'b1;
      hold_next = HOLD_LOAD;
    end else if (active_reg && !latched) begin
      if (hold_reg == '0) begin
        active_next = 1'b0;
      end else if (tick_i) begin
        hold_next = hold_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_reg <= 1'b0;
      hold_reg <= '0;
    end else begin
      active_reg <= active_next;
      hold_reg <= hold_next;
    end
  end

  assign active_o = active_reg;

endmodule : warn_cell

`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model
  import warn_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Requests from the bench
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] data_i,
  output logic done_o,
  output logic [31:0] rdata_o,
  output logic [1:0] resp_o,
  // AXI4-Lite master side
  output logic awvalid,
  input wire logic awready,
  output logic [ADDR_W-1:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  assign wstrb = 4'hF;
  // Released payloads flip so a stale value is never mistaken for fresh
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {awvalid, wvalid, arvalid, bready, rready, done_o} <= '0;
      {awaddr, wdata, araddr, rdata_o, resp_o} <= '0;
    end else begin
      done_o <= 1'b0;
      if (req_i && we_i) begin
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= addr_i;
        wdata <= data_i;
      end
      if (req_i && !we_i) begin
        {arvalid, rready} <= 2'h3;
        araddr <= addr_i;
      end
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
      if (bready && bvalid) begin
        {bready, done_o} <= 2'h1;
        resp_o <= bresp;
      end
      if (rready && rvalid) begin
        {rready, done_o} <= 2'h1;
        resp_o <= rresp;
        rdata_o <= rdata;
      end
    end
  end
endmodule : host_model
`default_nettype wire

// ==== tb/servo_warning_aggregator_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module servo_warning_aggregator_test;
  import warn_pkg::*;
  localparam int TL = 10;
  localparam int HL = 4;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0] dat = '0;
  logic [WARN_COUNT-1:0] cause = '0;
  logic pf = 1'b0, lu = 1'b0, top = 1'b0;
  logic done, o1, o2, irq, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic [31:0] rdat, wd, rd_;
  logic [1:0] rsp, brs, rrs;
  logic [3:0] ws;
  logic [ADDR_W-1:0] awa, ara;
  logic [WARN_COUNT-1:0] act;
  int mismatches = 0, checked = 0, w;
  logic [7:0] rnd = 8'h50;
  int tbl [0:7] = '{0, 1, 3, 4, 5, 6, 8, 9};

  always #5 mclk_i = ~mclk_i;

  host_model host_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req),
    .we_i(we), .addr_i(adr), .data_i(dat), .done_o(done), .rdata_o(rdat),
    .resp_o(rsp), .awvalid(awv), .awready(awr), .awaddr(awa), .wvalid(wv),
    .wready(wr_), .wdata(wd), .wstrb(ws), .bvalid(bv), .bready(br),
    .bresp(brs), .arvalid(arv), .arready(arr), .araddr(ara), .rvalid(rv),
    .rready(rr), .rdata(rd_), .rresp(rrs));

  warn_agg #(.TICK_LEN(TL), .HOLD_LEN(HL)) dut_u (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .awvalid(awv), .awready(awr), .awaddr(awa),
    .wvalid(wv), .wready(wr_), .wdata(wd), .wstrb(ws), .bvalid(bv),
    .bready(br), .bresp(brs), .arvalid(arv), .arready(arr), .araddr(ara),
    .rvalid(rv), .rready(rr), .rdata(rd_), .rresp(rrs),
    .warn_cause_i(cause), .supply_phase_fail_i(pf), .link_up_i(lu),
    .tool_op_i(top), .warn_out_one_o(o1), .warn_out_two_o(o2),
    .warn_active_o(act), .irq_o(irq));

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  function automatic logic [31:0] sel(input int a, input int b);
    return {19'h0, SEL_CODE[b], 3'h0, SEL_CODE[a]};
  endfunction : sel

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  // The bus wait ends on the handshake, or after a fixed 50 cycles counted as a mismatch
  task automatic acc(input logic wn, input logic [7:0] a, input int d);
    int n;
    n = 0;
    @(posedge mclk_i);
    req <= 1'b1;
    we <= wn;
    adr <= a;
    dat <= d;
    @(posedge mclk_i);
    req <= 1'b0;
    do begin
      cyc(1);
      n++;
    end while (done !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
  endtask : acc

  task automatic pin(input logic [WARN_COUNT-1:0] c);
    @(posedge mclk_i);
    cause <= c;
  endtask : pin

  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    cyc(3);
    resetn_i <= 1'b1;
    acc(0, OFS_CTRL, 0);
    chk(rdat, 32'h0);
    acc(0, 8'h3C, 0);
    chk(rsp, RESP_SLVERR);
    rnd = lfsr(lfsr(rnd));
    w = tbl[rnd[2:0]];
    pin(1 << w);
    cyc(8);
    chk(o1, 1'b1);
    acc(1, OFS_OUT_SEL, sel(w, W_TOOL_CMD));
    cyc(3);
    chk({o1, o2}, 2'h2);
    pin('0);
    cyc(20);
    chk(act[w], 1'b1);
    cyc(TL * HL * 2);
    chk(act[w], 1'b0);
    $display("test select and hold done");
    acc(1, OFS_CTRL, 1);
    pin(1 << w);
    cyc(6);
    pin('0);
    cyc(TL * HL * 3);
    chk(act[w], 1'b1);
    acc(1, OFS_CTRL, 3);
    cyc(4);
    chk(act, 16'h0);
    pin(1 << w);
    cyc(6);
    acc(1, OFS_CTRL, 3);
    cyc(4);
    chk(act[w], 1'b1);
    pin('0);
    acc(1, OFS_CTRL, 2);
    foreach (tbl[i]) if (i < 2) begin
      pin(i == 0 ? 16'h0004 : 16'h0080);
      cyc(6);
      pin('0);
      cyc(TL * HL * 3);
      chk(act, i == 0 ? 16'h0004 : 16'h0080);
      acc(1, OFS_CTRL, 2);
    end
    acc(1, OFS_CTRL, 4);
    pin(1 << W_BATTERY);
    cyc(8);
    chk(act[W_BATTERY], 1'b0);
    pin('0);
    acc(1, OFS_CTRL, 2);
    $display("test latch and clear done");
    acc(1, MASK_POS[w] < 16 ? OFS_MASK_PRIMARY : OFS_MASK_SECONDARY,
        1 << MASK_POS[w][3:0]);
    pin(1 << w | 1 << W_DETERIOR);
    cyc(8);
    chk(act[w], 1'b0);
    chk(act[W_DETERIOR], 1'b0);
    acc(1, OFS_FUNC_ENH_THREE, 2);
    cyc(8);
    chk(act[W_DETERIOR], 1'b1);
    pin('0);
    acc(1, OFS_MASK_PRIMARY, 0);
    acc(1, OFS_MASK_SECONDARY, 0);
    acc(1, OFS_CTRL, 2);
    acc(1, OFS_LINK_ENH_SIX, 1);
    top <= 1'b1;
    cyc(8);
    chk(act[W_TOOL_CMD], 1'b0);
    lu <= 1'b1;
    cyc(8);
    chk({act[W_TOOL_CMD], o2}, 2'h3);
    acc(1, OFS_MASK_SECONDARY, 16'h0100);
    acc(1, OFS_CTRL, 2);
    cyc(6);
    chk(act[W_TOOL_CMD], 1'b0);
    {top, lu} <= 2'h0;
    acc(1, OFS_MASK_SECONDARY, 0);
    $display("test mask and tool done");
    acc(1, OFS_PWR_TIME, 10);
    pf <= 1'b1;
    cyc(TL * 8);
    chk(act[W_POWER_OFF], 1'b0);
    cyc(TL * 5);
    chk(act[W_POWER_OFF], 1'b1);
    pf <= 1'b0;
    acc(1, OFS_CTRL, 2);
    acc(1, OFS_PWR_TIME, 5);
    pf <= 1'b1;
    cyc(TL * 13);
    chk(act[W_POWER_OFF], 1'b0);
    pf <= 1'b0;
    acc(0, OFS_IRQ_STATUS, 0);
    chk(rdat[W_POWER_OFF], 1'b1);
    acc(1, OFS_IRQ_MASK, 16'hFFFF);
    acc(1, OFS_EXT_DISABLE, 1);
    pin(16'h0800);
    cyc(8);
    chk({act[11], irq}, 2'h0);
    acc(1, OFS_EXT_DISABLE, 0);
    cyc(8);
    chk({act[11], irq}, 2'h3);
    acc(0, OFS_IRQ_STATUS, 0);
    chk(rdat[11], 1'b1);
    cyc(2);
    chk(irq, 1'b0);
    $display("test power and irq done");
    tally_and_finish();
  end
endmodule : servo_warning_aggregator_test
`default_nettype wire
